// *** rtl/lspf_ctrl.sv ***
// Contract
// R1: each switch follows its own enable bit
// R2: low-voltage switch by sequencer or host
// R3: 5V and HV switches host-controlled only
// R4: discharge bit pulls output low when off
// R5: power-fail trip disables switches marked shed
// R6: shed switch stays off until re-enabled; with seqsel_q at 1 the low switch follows SEQ_LS1_ON again once the trip ends
// R7: overcurrent flag while limiting, switch stays on
// R8: over-temperature forces off, auto recovers
// R9: fault flag while held off by over-temperature
// R10: 5V limit select two bits, overcurrent flag
// R11: 5V input undervoltage forces off, fault flag
// R12: HV switch two-bit current limit select
// R13: lockout trip starts power-down sequence
// R14: deep brown-out resets core, kills rails
// R15: fast rise tolerates 5 ms dip above 2.55V
// R16: slow rise needs hysteresis recovery within 5ms
// R17: power-fail affects nothing until enabled
// R18: power-fail enable bit starts power-down
// R19: power-fail state never visible to software
// R20: low switch off at power-down start; code clears it only when seqsel_q is 0
// R21: 5V and HV off 500 ms after trigger
// R22: latched flags drive combined interrupt output
`timescale 1ns/1ns
`default_nettype none
module lspf_ctrl
   import lspf_pkg::*;
#(
   parameter int UVLO_WIN = lspf_pkg::UVLO_WIN_CYC,
   parameter int PD_DELAY = lspf_pkg::PD_DELAY_CYC
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // analog comparators, asynchronous
   input wire logic PFI_TRIP,
   input wire logic [lspf_pkg::NSW-1:0] ILIM_ACTIVE,
   input wire logic [lspf_pkg::NSW-1:0] OT_ACTIVE,
   input wire logic LS2_IN_UV,
   input wire logic BIAS_BELOW_LOCKOUT,
   input wire logic BIAS_ABOVE_HYS,
   input wire logic BIAS_BELOW_2P55,
   input wire logic BIAS_BELOW_DEEP,
   input wire logic FAST_SLEW,
   // power sequencer, same clock
   input wire logic SEQ_LS1_ON,
   input wire logic SEQ_PD_BEGIN,
   output logic PWRDN_START,
   // load switches
   output logic [lspf_pkg::NSW-1:0] SW_ON,
   output logic [lspf_pkg::NSW-1:0] SW_DCHG,
   output logic [1:0] LS2_ILIM_SEL,
   output logic [1:0] LS3_ILIM_SEL,
   // rails and interrupt
   output logic RAIL_KILL,
   output logic [lspf_pkg::NCONV-1:0] CONV_DCHG,
   output logic INT_OUT
);
   import lspf_pkg::*;

   localparam int NSYNC = 13;

   // synchronised comparator levels
   logic [NSYNC-1:0] pins_s;
   logic pfi_s;
   logic [NSW-1:0] ilim_s;
   logic [NSW-1:0] ot_s;
   logic ls2_uv_s;
   logic below_lock_s;
   logic above_hys_s;
   logic below_2p55_s;
   logic deep_s;
   logic fast_pin_s;

   // free-running so the slew strap is settled by the time reset lifts
   lspf_sync #(.W(NSYNC)) u_sync (
      .clk(CORE_CLK),
      .rst_n(1'b1),
      .d({FAST_SLEW, BIAS_BELOW_DEEP, BIAS_BELOW_2P55, BIAS_ABOVE_HYS,
          BIAS_BELOW_LOCKOUT, LS2_IN_UV, OT_ACTIVE, ILIM_ACTIVE, PFI_TRIP}),
      .q(pins_s)
   );

   assign pfi_s = pins_s[0];
   assign ilim_s = pins_s[3:1];
   assign ot_s = pins_s[6:4];
   assign ls2_uv_s = pins_s[7];
   assign below_lock_s = pins_s[8];
   assign above_hys_s = pins_s[9];
   assign below_2p55_s = pins_s[10];
   assign deep_s = pins_s[11];
   assign fast_pin_s = pins_s[12];

   // deep brown-out acts as a core reset
   logic core_rst_n;
   assign core_rst_n = RST_N & ~deep_s; // R14

   // register state
   logic [NSW-1:0] en_q;
   logic [NSW-1:0] dchg_en_q;
   logic [NSW-1:0] shed_q;
   logic seqsel_q;
   logic pfpd_q;
   logic [1:0] ls2_lim_q;
   logic [1:0] ls3_lim_q;
   logic [NSW-1:0] oc_q;
   logic [NSW-1:0] flt_q;

   // ahb data phase
   logic wr_q;
   logic [7:0] addr_q;
   logic addr_ok;
   logic wr_en;
   logic wr_enable;
   logic wr_config;
   logic wr_flags;
   logic [31:0] rd_d;

   // slew strap caught once after reset release
   logic fast_q;
   logic strap_done_q;

   // sequencing state
   lspf_uv_t uv_q;
   lspf_pd_t pd_q;
   logic uv_trig;
   logic pfi_d_q;
   logic pfi_rise;
   logic pd_trig;
   logic pd_begin;
   logic pd_end;
   logic uv_recovered;
   logic uv_start;
   logic uv_abort;
   logic uv_done;
   logic pd_run;

   // switch datapath
   logic [NSW-1:0] req;
   logic [NSW-1:0] hold;
   logic [NSW-1:0] shed_now;
   logic [NSW-1:0] on_d;
   logic [NSW-1:0] dchg_d;
   logic [NSW-1:0] oc_set;
   logic [NSW-1:0] flt_set;
   logic [NSW-1:0] en_clr;

   // ---------------- ahb-lite slave ----------------
   // single-cycle slave: no wait states, always okay
   assign addr_ok = HSEL & HREADY & HTRANS[HTRANS_ACT_BIT];
   assign wr_en = wr_q;
   assign wr_enable = wr_en && (addr_q == OFS_ENABLE);
   assign wr_config = wr_en && (addr_q == OFS_CONFIG);
   assign wr_flags = wr_en && (addr_q == OFS_FLAGS);

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_q <= addr_ok & HWRITE;
         if (addr_ok) begin
            addr_q <= HADDR[7:0];
         end
      end
   end

   // read data built in the address phase so it comes from a flop
   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (HADDR[7:0])
         OFS_ENABLE: rd_d[NSW-1:0] = en_q;
         OFS_CONFIG: begin
            rd_d[CFG_DCHG_LSB +: NSW] = dchg_en_q;
            rd_d[CFG_SHED_LSB +: NSW] = shed_q;
            rd_d[CFG_SEQSEL_BIT] = seqsel_q;
            rd_d[CFG_PFPD_BIT] = pfpd_q;
            rd_d[CFG_LS2LIM_LSB +: 2] = ls2_lim_q;
            rd_d[CFG_LS3LIM_LSB +: 2] = ls3_lim_q;
         end
         OFS_FLAGS: begin
            rd_d[FLG_OC_LSB +: NSW] = oc_q;
            rd_d[FLG_FLT_LSB +: NSW] = flt_q;
         end
         // power-fail level deliberately absent here
         OFS_STATUS: begin // R19
            rd_d[ST_ON_LSB +: NSW] = SW_ON;
            rd_d[ST_PD_BIT] = (pd_q == PD_WAIT);
            rd_d[ST_UVWIN_BIT] = (uv_q == UV_DIP);
            rd_d[ST_FAST_BIT] = fast_q;
         end
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         HRDATA <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         if (addr_ok && !HWRITE) begin
            HRDATA <= rd_d;
         end
      end
   end

   // ---------------- configuration ----------------
   // defaults keep power-fail inert until software opts in
   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         dchg_en_q <= DCHG_RST; // R4
         shed_q <= SHED_RST; // R17
         seqsel_q <= SEQSEL_RST;
         pfpd_q <= PFPD_RST; // R17
         ls2_lim_q <= LIM_RST;
         ls3_lim_q <= LIM_RST;
      end else if (wr_config) begin
         dchg_en_q <= HWDATA[CFG_DCHG_LSB +: NSW];
         shed_q <= HWDATA[CFG_SHED_LSB +: NSW];
         seqsel_q <= HWDATA[CFG_SEQSEL_BIT];
         pfpd_q <= HWDATA[CFG_PFPD_BIT];
         ls2_lim_q <= HWDATA[CFG_LS2LIM_LSB +: 2]; // R10
         ls3_lim_q <= HWDATA[CFG_LS3LIM_LSB +: 2]; // R12
      end
   end

   // hardware clears win over a host write in the same cycle
   always_comb begin
      en_clr = shed_now; // R5 R6
      if (pd_begin && !seqsel_q) begin
         en_clr[SW_LOW] = 1'b1; // R20
      end
      if (pd_end) begin
         en_clr[SW_5V] = 1'b1; // R21
         en_clr[SW_HV] = 1'b1; // R21
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         en_q <= ENABLE_RST;
      end else if (wr_enable) begin
         en_q <= HWDATA[NSW-1:0] & ~en_clr; // R1
      end else begin
         en_q <= en_q & ~en_clr;
      end
   end

   // ---------------- slew strap ----------------
   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         fast_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         fast_q <= fast_pin_s;
         strap_done_q <= 1'b1;
      end
   end

   // ---------------- lockout dip window ----------------
   // fast rise only needs lockout again, slow rise needs the hysteresis
   assign uv_recovered = fast_q ? !below_lock_s : above_hys_s; // R15 R16
   assign uv_start = (uv_q == UV_RUN) && below_lock_s;
   assign uv_abort = (uv_q == UV_DIP) && uv_recovered;
   assign uv_trig = (uv_q == UV_DIP) && !uv_recovered
                    && (uv_done || (fast_q && below_2p55_s)); // R13 R15

   lspf_timer #(.W(TMR_W)) u_uv_tmr (
      .clk(CORE_CLK),
      .rst_n(core_rst_n),
      .start(uv_start),
      .abort(uv_abort),
      .load(TMR_W'(UVLO_WIN)),
      .running(),
      .done(uv_done)
   );

   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         uv_q <= UV_RUN;
      end else begin
         unique case (uv_q)
            UV_RUN: begin
               if (uv_start) begin
                  uv_q <= UV_DIP;
               end
            end
            UV_DIP: begin
               if (uv_abort) begin
                  uv_q <= UV_RUN;
               end else if (uv_trig) begin
                  uv_q <= UV_TRIP;
               end
            end
            UV_TRIP: begin
               if (uv_recovered) begin
                  uv_q <= UV_RUN;
               end
            end
         endcase
      end
   end

   // ---------------- power-down ----------------
   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         pfi_d_q <= 1'b0;
      end else begin
         pfi_d_q <= pfi_s;
      end
   end

   assign pfi_rise = pfi_s & ~pfi_d_q;
   assign pd_trig = uv_trig | (pfi_rise & pfpd_q) | SEQ_PD_BEGIN; // R13 R18
   assign pd_begin = (pd_q == PD_IDLE) && pd_trig;
   assign pd_end = (pd_q == PD_WAIT) && !pd_run && !pd_begin;

   lspf_timer #(.W(TMR_W)) u_pd_tmr (
      .clk(CORE_CLK),
      .rst_n(core_rst_n),
      .start(pd_begin),
      .abort(1'b0),
      .load(TMR_W'(PD_DELAY)),
      .running(pd_run),
      .done()
   );

   // a second trigger during the wait is absorbed
   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         pd_q <= PD_IDLE;
      end else begin
         unique case (pd_q)
            PD_IDLE: begin
               if (pd_begin) begin
                  pd_q <= PD_WAIT;
               end
            end
            PD_WAIT: begin
               if (pd_end) begin
                  pd_q <= PD_IDLE; // R21
               end
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         PWRDN_START <= 1'b0;
      end else begin
         PWRDN_START <= uv_trig | (pfi_rise & pfpd_q); // R13 R18
      end
   end

   // ---------------- per-switch logic ----------------
   // sequencer reaches only the low-voltage switch
   assign req[SW_LOW] = seqsel_q ? SEQ_LS1_ON : en_q[SW_LOW]; // R2
   assign req[SW_5V] = en_q[SW_5V]; // R3
   assign req[SW_HV] = en_q[SW_HV]; // R3

   genvar i;
   generate
      for (i = 0; i < NSW; i++) begin : g_sw
         if (i == SW_5V) begin : g_uv
            assign hold[i] = ot_s[i] | ls2_uv_s; // R8 R11
         end else begin : g_ot
            assign hold[i] = ot_s[i]; // R8
         end
         assign shed_now[i] = pfi_s & shed_q[i]; // R5 R17
         assign on_d[i] = req[i] & ~hold[i] & ~shed_now[i]; // R1
         assign dchg_d[i] = dchg_en_q[i] & ~on_d[i]; // R4
         // limiting keeps the switch on, only flags it
         assign oc_set[i] = ilim_s[i] & SW_ON[i]; // R7 R10
         assign flt_set[i] = req[i] & hold[i]; // R9 R11
      end
   endgenerate

   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         SW_ON <= '0;
         SW_DCHG <= '0;
      end else begin
         SW_ON <= on_d;
         SW_DCHG <= dchg_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         LS2_ILIM_SEL <= LIM_RST;
         LS3_ILIM_SEL <= LIM_RST;
      end else begin
         LS2_ILIM_SEL <= ls2_lim_q; // R10
         LS3_ILIM_SEL <= ls3_lim_q; // R12
      end
   end

   // ---------------- flags and interrupt ----------------
   // write one to clear; a new event in the same cycle survives
   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         oc_q <= '0;
         flt_q <= '0;
      end else if (wr_flags) begin
         oc_q <= (oc_q & ~HWDATA[FLG_OC_LSB +: NSW]) | oc_set; // R22
         flt_q <= (flt_q & ~HWDATA[FLG_FLT_LSB +: NSW]) | flt_set; // R22
      end else begin
         oc_q <= oc_q | oc_set; // R7
         flt_q <= flt_q | flt_set; // R9
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!core_rst_n) begin
         INT_OUT <= 1'b0;
      end else begin
         INT_OUT <= (|(oc_q | oc_set)) | (|(flt_q | flt_set)); // R22
      end
   end

   // ---------------- deep brown-out ----------------
   // held on RST_N only so the kill survives the core reset
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         RAIL_KILL <= 1'b0;
         CONV_DCHG <= '0;
      end else begin
         RAIL_KILL <= deep_s; // R14
         CONV_DCHG <= {NCONV{deep_s}}; // R14
      end
   end

endmodule : lspf_ctrl
`default_nettype wire

// *** rtl/lspf_pkg.sv ***
package lspf_pkg;

   // clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int UVLO_WIN_MS = 5;
   localparam int PD_DELAY_MS = 500;
   localparam int UVLO_WIN_CYC = (CLK_HZ / 1000) * UVLO_WIN_MS;
   localparam int PD_DELAY_CYC = (CLK_HZ / 1000) * PD_DELAY_MS;
   localparam int TMR_W = 25;

   // switch indices
   localparam int NSW = 3;
   localparam int SW_LOW = 0;
   localparam int SW_5V = 1;
   localparam int SW_HV = 2;
   localparam int NCONV = 5;

   // register byte offsets
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   // field positions
   localparam int CFG_DCHG_LSB = 0;
   localparam int CFG_SHED_LSB = 4;
   localparam int CFG_SEQSEL_BIT = 8;
   localparam int CFG_PFPD_BIT = 9;
   localparam int CFG_LS2LIM_LSB = 12;
   localparam int CFG_LS3LIM_LSB = 16;
   localparam int FLG_OC_LSB = 0;
   localparam int FLG_FLT_LSB = 4;
   localparam int ST_ON_LSB = 0;
   localparam int ST_PD_BIT = 4;
   localparam int ST_UVWIN_BIT = 5;
   localparam int ST_FAST_BIT = 6;

   // reset values
   localparam logic [2:0] ENABLE_RST = 3'h0;
   localparam logic [2:0] DCHG_RST = 3'h0;
   localparam logic [2:0] SHED_RST = 3'h0;
   localparam logic SEQSEL_RST = 1'h0;
   localparam logic PFPD_RST = 1'h0;
   localparam logic [1:0] LIM_RST = 2'h0;

   localparam int HTRANS_ACT_BIT = 1;

   typedef enum logic [1:0] {UV_RUN, UV_DIP, UV_TRIP} lspf_uv_t;
   typedef enum logic {PD_IDLE, PD_WAIT} lspf_pd_t;

endpackage : lspf_pkg

// *** rtl/lspf_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module lspf_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : lspf_sync
`default_nettype wire

// *** rtl/lspf_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module lspf_timer #(
   parameter int W = 25
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic [W-1:0] load,
   // state
   output logic running,
   output logic done
);
   logic [W-1:0] cnt_q;

   // load of zero is treated as one cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_q <= load;
            running <= 1'b1;
         end else if (abort) begin
            running <= 1'b0;
         end else if (running) begin
            if (cnt_q <= W'(1)) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - W'(1);
            end
         end
      end
   end
endmodule : lspf_timer
`default_nettype wire

// *** tb/lspf_ctrl_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module lspf_ctrl_chk #(
   parameter int UVLO_WIN = 20
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // bus request
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   // comparators
   input wire logic [2:0] ILIM_ACTIVE,
   input wire logic [2:0] OT_ACTIVE,
   input wire logic LS2_IN_UV,
   input wire logic BIAS_BELOW_LOCKOUT,
   input wire logic BIAS_ABOVE_HYS,
   input wire logic BIAS_BELOW_DEEP,
   // outputs watched
   input wire logic PWRDN_START,
   input wire logic [2:0] SW_ON,
   input wire logic [2:0] SW_DCHG,
   input wire logic RAIL_KILL,
   input wire logic [4:0] CONV_DCHG,
   input wire logic INT_OUT
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   logic [3:0] wr_q;
   int dip_q;
   logic seen_q;
   // a flag may only drop after a write or a deep brown-out shortly before
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) wr_q <= 4'h0;
      else wr_q <= {wr_q[2:0], (HSEL && HTRANS[1] && HWRITE) || BIAS_BELOW_DEEP};
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || !(BIAS_BELOW_LOCKOUT && !BIAS_ABOVE_HYS && !BIAS_BELOW_DEEP)) dip_q <= 0;
      else if (dip_q < 1000) dip_q <= dip_q + 1;
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || dip_q == 0) seen_q <= 1'b0;
      else if (PWRDN_START) seen_q <= 1'b1;
   end
   property p_ot_off; OT_ACTIVE[2][*3] |=> !SW_ON[2]; endproperty
   property p_uv_off; LS2_IN_UV[*3] |=> !SW_ON[1]; endproperty
   property p_oc_flag; (ILIM_ACTIVE[0] && SW_ON[0] && !BIAS_BELOW_DEEP)[*4] |=> INT_OUT; endproperty
   property p_int_hold; $fell(INT_OUT) |-> wr_q != 4'h0; endproperty
   property p_deep; BIAS_BELOW_DEEP[*4] |=> RAIL_KILL && CONV_DCHG == 5'h1F && SW_ON == 3'h0;
   endproperty
   property p_dchg; (SW_DCHG & SW_ON) == 3'h0; endproperty
   property p_pulse; PWRDN_START |=> !PWRDN_START; endproperty
   // window expiry without recovery must have started the power-down
   property p_dip; dip_q == UVLO_WIN + 8 |-> seen_q; endproperty
   a_ot_off: assert property (p_ot_off)
      else $error("switch on under over-temperature");
   a_uv_off: assert property (p_uv_off)
      else $error("five volt switch on under input undervoltage");
   a_oc_flag: assert property (p_oc_flag)
      else $error("no interrupt while limiting");
   a_int_hold: assert property (p_int_hold)
      else $error("interrupt dropped without clear");
   a_deep: assert property (p_deep)
      else $error("rails not killed on deep brown-out");
   a_dchg: assert property (p_dchg)
      else $error("discharge on an enabled switch");
   a_pulse: assert property (p_pulse)
      else $error("power-down request longer than one cycle");
   a_dip: assert property (p_dip)
      else $error("lockout dip did not start power-down");
   c_pd: cover property (PWRDN_START);
   c_kill: cover property (RAIL_KILL);
   c_clear: cover property ($fell(INT_OUT));
endmodule : lspf_ctrl_chk
bind lspf_ctrl lspf_ctrl_chk #(.UVLO_WIN(UVLO_WIN)) lspf_ctrl_chk_i (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .ILIM_ACTIVE(ILIM_ACTIVE), .OT_ACTIVE(OT_ACTIVE), .LS2_IN_UV(LS2_IN_UV),
   .BIAS_BELOW_LOCKOUT(BIAS_BELOW_LOCKOUT), .BIAS_ABOVE_HYS(BIAS_ABOVE_HYS),
   .BIAS_BELOW_DEEP(BIAS_BELOW_DEEP), .PWRDN_START(PWRDN_START), .SW_ON(SW_ON),
   .SW_DCHG(SW_DCHG), .RAIL_KILL(RAIL_KILL), .CONV_DCHG(CONV_DCHG), .INT_OUT(INT_OUT));
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lspf_pkg::*;
   localparam int UW = 20;
   localparam int PD = 50;
   localparam logic [31:0] FL [3] = '{32'h40, 32'h20, 32'h07};
   logic CORE_CLK, RST_N, HSEL, HWRITE, PFI_TRIP, LS2_IN_UV, FAST_SLEW, SEQ_LS1_ON, SEQ_PD_BEGIN;
   logic BIAS_BELOW_LOCKOUT, BIAS_ABOVE_HYS, BIAS_BELOW_2P55, BIAS_BELOW_DEEP;
   logic HREADYOUT, HRESP, PWRDN_START, RAIL_KILL, INT_OUT;
   logic [31:0] HADDR, HWDATA, HRDATA, rd, en, cfg;
   logic [1:0] HTRANS, LS2_ILIM_SEL, LS3_ILIM_SEL, lim;
   logic [2:0] ILIM_ACTIVE, OT_ACTIVE, SW_ON, SW_DCHG, eo;
   logic [4:0] CONV_DCHG;
   int n_fail, n_compared, n_pd;
   lspf_ctrl #(.UVLO_WIN(UW), .PD_DELAY(PD)) lspf_ctrl_i (
      .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PFI_TRIP(PFI_TRIP), .ILIM_ACTIVE(ILIM_ACTIVE),
      .OT_ACTIVE(OT_ACTIVE), .LS2_IN_UV(LS2_IN_UV), .BIAS_BELOW_LOCKOUT(BIAS_BELOW_LOCKOUT),
      .BIAS_ABOVE_HYS(BIAS_ABOVE_HYS), .BIAS_BELOW_2P55(BIAS_BELOW_2P55),
      .BIAS_BELOW_DEEP(BIAS_BELOW_DEEP), .FAST_SLEW(FAST_SLEW), .SEQ_LS1_ON(SEQ_LS1_ON),
      .SEQ_PD_BEGIN(SEQ_PD_BEGIN), .PWRDN_START(PWRDN_START), .SW_ON(SW_ON), .SW_DCHG(SW_DCHG),
      .LS2_ILIM_SEL(LS2_ILIM_SEL), .LS3_ILIM_SEL(LS3_ILIM_SEL), .RAIL_KILL(RAIL_KILL),
      .CONV_DCHG(CONV_DCHG), .INT_OUT(INT_OUT));
   initial begin
      CORE_CLK = 1'b0;
      forever #10 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK) if (PWRDN_START === 1'b1) n_pd++;
   task automatic tick(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one single transfer; the slave's ready decides every step
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : bus
   function automatic logic [2:0] exp_on(input logic [31:0] e, input logic [31:0] c, input logic s);
      return {e[2:1], c[CFG_SEQSEL_BIT] ? s : e[0]};
   endfunction : exp_on
   task automatic do_reset(input logic fast);
      RST_N <= 1'b0;
      FAST_SLEW <= fast;
      tick(20);
      RST_N <= 1'b1;
      tick(2);
   endtask : do_reset
   // dip of the bias supply, then wait out any power-down it started
   task automatic dip(input int len, input logic hys, input logic b255, input int exp);
      BIAS_BELOW_LOCKOUT <= 1'b1;
      BIAS_BELOW_2P55 <= b255;
      BIAS_ABOVE_HYS <= 1'b0;
      tick(len);
      BIAS_BELOW_LOCKOUT <= 1'b0;
      BIAS_BELOW_2P55 <= 1'b0;
      BIAS_ABOVE_HYS <= hys;
      tick(UW + 10);
      chk(n_pd, exp);
      BIAS_ABOVE_HYS <= 1'b1;
      tick(PD + 10);
   endtask : dip
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   initial begin
      tick(5000);
      n_fail++;
      results();
   end
   initial begin
      {HSEL, HWRITE, PFI_TRIP, LS2_IN_UV, SEQ_LS1_ON, SEQ_PD_BEGIN, FAST_SLEW} = '0;
      {BIAS_BELOW_LOCKOUT, BIAS_BELOW_2P55, BIAS_BELOW_DEEP, RST_N} = '0;
      {HADDR, HWDATA, HTRANS, ILIM_ACTIVE, OT_ACTIVE} = '0;
      BIAS_ABOVE_HYS = 1'b1;
      rd = $urandom(85861);
      do_reset(1'b0);
      chk({HREADYOUT, HRESP, SW_ON}, 5'h10);
      // status and the unmapped word must ignore writes
      bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
      bus(1'b1, 8'h10, 32'hFFFF_FFFF);
      for (int a = 0; a < 5; a++) begin
         bus(1'b0, 8'(a * 4), 32'h0);
         chk(rd, 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
         lim = i[1:0];
         en = $urandom & 32'h7;
         cfg = ($urandom & 32'h177) | {14'h0, ~lim, 2'h0, lim, 12'h0};
         SEQ_LS1_ON <= 1'($urandom);
         bus(1'b1, OFS_ENABLE, en);
         bus(1'b1, OFS_CONFIG, cfg);
         tick(2);
         eo = exp_on(en, cfg, SEQ_LS1_ON);
         chk(SW_ON, eo);
         chk(SW_DCHG, cfg[2:0] & ~eo);
         chk({LS3_ILIM_SEL, LS2_ILIM_SEL}, {cfg[17:16], cfg[13:12]});
         bus(1'b0, OFS_CONFIG, 32'h0);
         chk(rd, cfg);
      end
      bus(1'b1, OFS_CONFIG, 32'h0);
      bus(1'b1, OFS_ENABLE, 32'h7);
      for (int k = 0; k < 3; k++) begin
         OT_ACTIVE <= k == 0 ? 3'h4 : 3'h0;
         LS2_IN_UV <= k == 1;
         ILIM_ACTIVE <= k == 2 ? 3'h7 : 3'h0;
         tick(5);
         chk(SW_ON, k == 0 ? 3'h3 : k == 1 ? 3'h5 : 3'h7);
         chk(INT_OUT, 1'b1);
         // clearing while the cause stands must not lose the flag
         bus(1'b1, OFS_FLAGS, 32'h77);
         bus(1'b0, OFS_FLAGS, 32'h0);
         chk(rd, FL[k]);
         {OT_ACTIVE, LS2_IN_UV, ILIM_ACTIVE} <= '0;
         tick(5);
         chk(SW_ON, 3'h7);
         bus(1'b0, OFS_FLAGS, 32'h0);
         chk(rd, FL[k]);
         bus(1'b1, OFS_FLAGS, FL[k]);
         tick(2);
         chk(INT_OUT, 1'b0);
      end
      PFI_TRIP <= 1'b1;
      tick(6);
      chk({n_pd[3:0], 1'b0, SW_ON}, 8'h07);
      PFI_TRIP <= 1'b0;
      tick(4);
      bus(1'b1, OFS_CONFIG, 32'h50);
      PFI_TRIP <= 1'b1;
      tick(6);
      chk(SW_ON, 3'h2);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h2);
      PFI_TRIP <= 1'b0;
      tick(6);
      chk(SW_ON, 3'h2);
      bus(1'b1, OFS_ENABLE, 32'h7);
      tick(2);
      chk(SW_ON, 3'h7);
      bus(1'b1, OFS_CONFIG, 32'h200);
      PFI_TRIP <= 1'b1;
      tick(6);
      chk({n_pd[3:0], 1'b0, SW_ON}, 8'h16);
      tick(PD - 12);
      chk(SW_ON, 3'h6);
      tick(15);
      chk(SW_ON, 3'h0);
      PFI_TRIP <= 1'b0;
      bus(1'b1, OFS_ENABLE, 32'h7);
      SEQ_PD_BEGIN <= 1'b1;
      tick(1);
      SEQ_PD_BEGIN <= 1'b0;
      tick(3);
      chk({n_pd[3:0], 1'b0, SW_ON}, 8'h16);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h16);
      tick(PD + 5);
      chk(SW_ON, 3'h0);
      dip(UW - 8, 1'b1, 1'b0, 1);
      dip(UW + 12, 1'b1, 1'b0, 2);
      dip(UW - 8, 1'b0, 1'b0, 3);
      do_reset(1'b1);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h40);
      dip(UW - 8, 1'b0, 1'b0, 3);
      dip(8, 1'b1, 1'b1, 4);
      bus(1'b1, OFS_ENABLE, 32'h7);
      tick(2);
      BIAS_BELOW_DEEP <= 1'b1;
      tick(6);
      chk({RAIL_KILL, CONV_DCHG, SW_ON}, 9'h1F8);
      BIAS_BELOW_DEEP <= 1'b0;
      tick(4);
      bus(1'b0, OFS_ENABLE, 32'h0);
      chk(rd, 32'h0);
      results();
   end
endmodule : testbench
`default_nettype wire
